/* File: rtl/ccrs_pkg.sv */
package ccrs_pkg;

  // ---------------------------------------------------------------
  // register map, byte addresses on the AXI4-Lite slave
  // ---------------------------------------------------------------
  localparam logic [7:0] ADDR_PWR_CTRL = 8'h00;
  localparam logic [7:0] ADDR_SERDIV = 8'h04;
  localparam logic [7:0] ADDR_SPI_RATE = 8'h08;
  localparam logic [7:0] ADDR_STATUS = 8'h0C;

  localparam logic [1:0] RESP_OKAY = 2'h0;
  localparam logic [1:0] RESP_SLVERR = 2'h2;

  // power management control fields
  localparam int MULT_LSB = 0;
  localparam int MULT_W = 7;
  localparam int DIVN_LSB = 8;
  localparam int DIVN_W = 2;
  localparam int INDIV_BIT = 10;
  localparam int DRAM_LSB = 18;
  localparam int DRAM_W = 3;
  localparam logic [31:0] PWR_CTRL_RST = 32'h0000_0110; // multiplier 16, divider 1, input divider off

  // strap ratio table, core clock over reference clock
  localparam logic [6:0] STRAP_MULT_00 = 7'h10;
  localparam logic [6:0] STRAP_MULT_01 = 7'h20;
  localparam logic [6:0] STRAP_MULT_10 = 7'h06;
  localparam logic [6:0] STRAP_MULT_11 = 7'h10;
  localparam logic [1:0] STRAP_DIVN = 2'h1;

  // divider registers
  localparam int RATIO_W = 16;
  localparam logic [31:0] SERDIV_RST = 32'h0000_0004;
  localparam logic [31:0] SPI_RATE_RST = 32'h0000_0004;

  // status fields
  localparam int STAT_REL_BIT = 0;
  localparam int STAT_STRAP_LSB = 1;
  localparam int STAT_CNT_LSB = 4;

  // core reset delay
  localparam int REF_CNT_W = 13;
  localparam logic [12:0] REF_CYCLES = 13'h1000;
  localparam logic [1:0] TAIL_CYCLES = 2'h2;

  typedef enum logic [1:0] {
    SEQ_HOLD,
    SEQ_COUNT,
    SEQ_TAIL,
    SEQ_RUN
  } ccrs_seq_t;

  typedef struct packed {
    logic awvalid;
    logic [7:0] awaddr;
    logic wvalid;
    logic [31:0] wdata;
    logic [3:0] wstrb;
    logic bready;
    logic arvalid;
    logic [7:0] araddr;
    logic rready;
  } ccrs_axi_req_t;

  typedef struct packed {
    logic awready;
    logic wready;
    logic bvalid;
    logic [1:0] bresp;
    logic arready;
    logic rvalid;
    logic [31:0] rdata;
    logic [1:0] rresp;
  } ccrs_axi_rsp_t;

endpackage

/* File: rtl/ccrs_core_clock_reset.sv */
`timescale 1ns/1ps
// Overview of operation
// - While the reset pin is low, the ratio straps set the core-to-reference ratio.
// - Software may set other ratios through the multiplier and divider fields of the control register.
// - Core frequency is two times multiplier times PLL input, over two times divider.
// - The PLL input is the reference clock, or half of it when the input divider is on.
// - The peripheral clock has twice the core clock period.
// - The serial port bit clock period is the peripheral period times the serial divide ratio.
// - The SPI clock period is the peripheral period times the SPI rate setting.
// - The DRAM clock period is the core period times the ratio in control bits 20-18.
// - Core reset is released 4096 reference cycles plus two core cycles after the pin is released.
// - A missed pin setup may add one reference cycle, to 4097 at most.
// - With default settings the core runs at sixteen times the reference clock.
module ccrs_core_clock_reset (
  input wire logic clk,
  input wire logic rst_n,
  input wire logic refClkIn,
  input wire logic resetPin_n,
  input wire logic [1:0] ratioStrapPins,
  input ccrs_pkg::ccrs_axi_req_t axiReq,
  output ccrs_pkg::ccrs_axi_rsp_t axiRsp,
  output logic coreReset_n,
  output logic [6:0] coreMult,
  output logic [2:0] coreDiv,
  output logic periphTick,
  output logic serialTick,
  output logic spiTick,
  output logic dramTick
);

  // ---------------------------------------------------------------
  // state
  // ---------------------------------------------------------------
  typedef struct packed {
    logic bvalid;
    logic [1:0] bresp;
    logic rvalid;
    logic [1:0] rresp;
    logic [31:0] rdata;
    logic [31:0] pwrCtrl;
    logic [31:0] serDiv;
    logic [31:0] spi_rate_setting;
    ccrs_pkg::ccrs_seq_t seq;
    logic [12:0] refCnt;
    logic [1:0] tailCnt;
    logic refPrev;
    logic coreRelease;
    logic perPhase;
    logic periphTick;
    logic [15:0] serCnt;
    logic serialTick;
    logic [15:0] spiCnt;
    logic spiTick;
    logic [15:0] dramCnt;
    logic dramTick;
  } ccrs_state_t;

  ccrs_state_t st_reg;
  ccrs_state_t st_next;

  // ---------------------------------------------------------------
  // helpers
  // ---------------------------------------------------------------
  // ratio of 0 or 1 gives a tick every source tick
  function automatic logic ratioDone(input logic [15:0] cnt, input logic [15:0] ratio);
    ratioDone = (ratio <= 16'h0001) || (cnt == ratio - 16'h0001);
  endfunction

  function automatic logic [31:0] byteMerge(input logic [31:0] old, input logic [31:0] wd, input logic [3:0] be);
    logic [31:0] res;
    res = old;
    for (int i = 0; i < 4; i++) begin
      if (be[i]) begin
        res[8*i +: 8] = wd[8*i +: 8];
      end
    end
    byteMerge = res;
  endfunction

  function automatic logic [6:0] strapMult(input logic [1:0] strap);
    logic [6:0] m;
    m = ccrs_pkg::STRAP_MULT_00;
    unique case (strap)
      2'h0: m = ccrs_pkg::STRAP_MULT_00;
      2'h1: m = ccrs_pkg::STRAP_MULT_01;
      2'h2: m = ccrs_pkg::STRAP_MULT_10;
      2'h3: m = ccrs_pkg::STRAP_MULT_11;
    endcase
    strapMult = m;
  endfunction

  logic refRise;
  logic wrGo;
  logic rdGo;
  logic [15:0] serRatio;
  logic [15:0] spiRatio;
  logic [15:0] dramRatio;
  logic [2:0] divN;

  assign serRatio = st_reg.serDiv[ccrs_pkg::RATIO_W-1:0];
  assign spiRatio = st_reg.spi_rate_setting[ccrs_pkg::RATIO_W-1:0];
  assign dramRatio = {13'h0000, st_reg.pwrCtrl[ccrs_pkg::DRAM_LSB +: ccrs_pkg::DRAM_W]};
  assign divN = {1'b0, st_reg.pwrCtrl[ccrs_pkg::DIVN_LSB +: ccrs_pkg::DIVN_W]};
  // reference edges come in as a plain synchronous level
  // a level already high when the pin lets go is no rise, so the delay may grow by one reference cycle
  assign refRise = refClkIn & ~st_reg.refPrev;
  // write waits for address and data together, one transfer outstanding
  assign wrGo = axiReq.awvalid & axiReq.wvalid & ~st_reg.bvalid;
  assign rdGo = axiReq.arvalid & ~st_reg.rvalid;

  // ---------------------------------------------------------------
  // next state
  // ---------------------------------------------------------------
  always_comb begin
    st_next = st_reg;
    st_next.refPrev = refClkIn;

    // peripheral rate: one tick every second core cycle
    st_next.perPhase = ~st_reg.perPhase;
    st_next.periphTick = st_reg.perPhase;

    // serial and SPI bit rates count peripheral ticks
    st_next.serialTick = 1'b0;
    st_next.spiTick = 1'b0;
    if (st_reg.perPhase) begin
      if (ratioDone(st_reg.serCnt, serRatio)) begin
        st_next.serCnt = 16'h0000;
        st_next.serialTick = 1'b1;
      end else begin
        st_next.serCnt = st_reg.serCnt + 16'h0001;
      end
      if (ratioDone(st_reg.spiCnt, spiRatio)) begin
        st_next.spiCnt = 16'h0000;
        st_next.spiTick = 1'b1;
      end else begin
        st_next.spiCnt = st_reg.spiCnt + 16'h0001;
      end
    end

    // dram rate counts core cycles
    if (ratioDone(st_reg.dramCnt, dramRatio)) begin
      st_next.dramCnt = 16'h0000;
      st_next.dramTick = 1'b1;
    end else begin
      st_next.dramCnt = st_reg.dramCnt + 16'h0001;
      st_next.dramTick = 1'b0;
    end

    // register writes
    if (wrGo) begin
      st_next.bvalid = 1'b1;
      st_next.bresp = ccrs_pkg::RESP_OKAY;
      unique case (axiReq.awaddr)
        ccrs_pkg::ADDR_PWR_CTRL: st_next.pwrCtrl = byteMerge(st_reg.pwrCtrl, axiReq.wdata, axiReq.wstrb);
        ccrs_pkg::ADDR_SERDIV: st_next.serDiv = byteMerge(st_reg.serDiv, axiReq.wdata, axiReq.wstrb);
        ccrs_pkg::ADDR_SPI_RATE: st_next.spi_rate_setting = byteMerge(st_reg.spi_rate_setting, axiReq.wdata, axiReq.wstrb);
        ccrs_pkg::ADDR_STATUS: st_next.bresp = ccrs_pkg::RESP_OKAY; // read-only, write ignored
        default: st_next.bresp = ccrs_pkg::RESP_SLVERR;
      endcase
    end else if (st_reg.bvalid && axiReq.bready) begin
      st_next.bvalid = 1'b0;
    end

    // register reads
    if (rdGo) begin
      st_next.rvalid = 1'b1;
      st_next.rresp = ccrs_pkg::RESP_OKAY;
      st_next.rdata = 32'h0000_0000;
      unique case (axiReq.araddr)
        ccrs_pkg::ADDR_PWR_CTRL: st_next.rdata = st_reg.pwrCtrl;
        ccrs_pkg::ADDR_SERDIV: st_next.rdata = st_reg.serDiv;
        ccrs_pkg::ADDR_SPI_RATE: st_next.rdata = st_reg.spi_rate_setting;
        ccrs_pkg::ADDR_STATUS: begin
          st_next.rdata[ccrs_pkg::STAT_REL_BIT] = st_reg.coreRelease;
          st_next.rdata[ccrs_pkg::STAT_STRAP_LSB +: 2] = ratioStrapPins;
          st_next.rdata[ccrs_pkg::STAT_CNT_LSB +: ccrs_pkg::REF_CNT_W] = st_reg.refCnt;
        end
        default: st_next.rresp = ccrs_pkg::RESP_SLVERR;
      endcase
    end else if (st_reg.rvalid && axiReq.rready) begin
      st_next.rvalid = 1'b0;
    end

    // core reset sequencer
    unique case (st_reg.seq)
      ccrs_pkg::SEQ_HOLD: begin
        st_next.seq = ccrs_pkg::SEQ_COUNT;
      end
      ccrs_pkg::SEQ_COUNT: begin
        if (refRise) begin
          if (st_reg.refCnt == ccrs_pkg::REF_CYCLES - 13'h0001) begin
            st_next.seq = ccrs_pkg::SEQ_TAIL;
            st_next.tailCnt = 2'h0;
          end else begin
            st_next.refCnt = st_reg.refCnt + 13'h0001;
          end
        end
      end
      ccrs_pkg::SEQ_TAIL: begin
        if (st_reg.tailCnt == ccrs_pkg::TAIL_CYCLES - 2'h1) begin
          st_next.seq = ccrs_pkg::SEQ_RUN;
        end else begin
          st_next.tailCnt = st_reg.tailCnt + 2'h1;
        end
      end
      ccrs_pkg::SEQ_RUN: begin
        st_next.seq = ccrs_pkg::SEQ_RUN;
      end
    endcase

    // pin low overrides the sequencer and any control register write: straps reload the ratio, delay restarts
    if (!resetPin_n) begin
      st_next.seq = ccrs_pkg::SEQ_HOLD;
      st_next.refCnt = 13'h0000;
      st_next.tailCnt = 2'h0;
      st_next.pwrCtrl = ccrs_pkg::PWR_CTRL_RST;
      st_next.pwrCtrl[ccrs_pkg::MULT_LSB +: ccrs_pkg::MULT_W] = strapMult(ratioStrapPins);
      st_next.pwrCtrl[ccrs_pkg::DIVN_LSB +: ccrs_pkg::DIVN_W] = ccrs_pkg::STRAP_DIVN;
    end
    st_next.coreRelease = (st_next.seq == ccrs_pkg::SEQ_RUN);
  end

  // ---------------------------------------------------------------
  // state register
  // ---------------------------------------------------------------
  always_ff @(posedge clk or negedge rst_n) begin
    if (!rst_n) begin
      st_reg <= '0;
      st_reg.seq <= ccrs_pkg::SEQ_HOLD;
      st_reg.pwrCtrl <= ccrs_pkg::PWR_CTRL_RST;
      st_reg.serDiv <= ccrs_pkg::SERDIV_RST;
      st_reg.spi_rate_setting <= ccrs_pkg::SPI_RATE_RST;
    end else begin
      st_reg <= st_next;
    end
  end

  // ---------------------------------------------------------------
  // outputs
  // ---------------------------------------------------------------
  // ratio = mult / (div * indiv); the factors of two in the formula cancel
  assign coreMult = st_reg.pwrCtrl[ccrs_pkg::MULT_LSB +: ccrs_pkg::MULT_W];
  assign coreDiv = st_reg.pwrCtrl[ccrs_pkg::INDIV_BIT] ? {divN[1:0], 1'b0} : divN;
  assign coreReset_n = st_reg.coreRelease;
  assign periphTick = st_reg.periphTick;
  assign serialTick = st_reg.serialTick;
  assign spiTick = st_reg.spiTick;
  assign dramTick = st_reg.dramTick;

  always_comb begin
    axiRsp.awready = wrGo;
    axiRsp.wready = wrGo;
    axiRsp.bvalid = st_reg.bvalid;
    axiRsp.bresp = st_reg.bresp;
    axiRsp.arready = ~st_reg.rvalid;
    axiRsp.rvalid = st_reg.rvalid;
    axiRsp.rdata = st_reg.rdata;
    axiRsp.rresp = st_reg.rresp;
  end

  // ---------------------------------------------------------------
  // checks
  // ---------------------------------------------------------------
  default clocking cb @(posedge clk); endclocking
  default disable iff (!rst_n);

  sequence perPulse;
    periphTick ##1 !periphTick ##1 periphTick;
  endsequence

  sequence countEnd;
    resetPin_n && refRise && st_reg.seq == ccrs_pkg::SEQ_COUNT
      && st_reg.refCnt == ccrs_pkg::REF_CYCLES - 13'h0001;
  endsequence

  // the first tail cycle is seen through $past, so the walk is judged where the pin checks end
  sequence tailWalk;
    $past(st_reg.seq) == ccrs_pkg::SEQ_TAIL && st_reg.seq == ccrs_pkg::SEQ_TAIL ##1 coreReset_n;
  endsequence

  chk_strap_load: assert property (!resetPin_n |=> coreMult == strapMult($past(ratioStrapPins)))
    else $error("strap ratio not loaded during reset");
  chk_soft_ratio: assert property ((wrGo && resetPin_n && axiReq.awaddr == ccrs_pkg::ADDR_PWR_CTRL
    && axiReq.wstrb[0]) |=> coreMult == $past(axiReq.wdata[6:0]))
    else $error("multiplier write lost");
  chk_indiv_double: assert property (st_reg.pwrCtrl[ccrs_pkg::INDIV_BIT] |-> coreDiv == 2 * divN)
    else $error("input divider not applied");
  chk_periph_half: assert property (periphTick |-> perPulse)
    else $error("peripheral tick not every second cycle");
  chk_dram_two: assert property ((dramTick && dramRatio == 16'h0002 && resetPin_n && !wrGo)
    |=> !dramTick ##1 dramTick)
    else $error("dram tick spacing wrong");
  chk_pin_hold: assert property (!resetPin_n |=> !coreReset_n ##0 st_reg.refCnt == 13'h0000)
    else $error("core left reset while pin low");
  chk_tail_release: assert property (countEnd ##1 resetPin_n [*2] |-> tailWalk)
    else $error("core reset not released two cycles after count");
  chk_release_count: assert property ($rose(coreReset_n) |-> $past(st_reg.refCnt, 3)
    == ccrs_pkg::REF_CYCLES - 13'h0001)
    else $error("core reset released before full count");
  chk_bad_addr: assert property ((wrGo && axiReq.awaddr == 8'hF0) |=> axiRsp.bvalid
    && axiRsp.bresp == ccrs_pkg::RESP_SLVERR)
    else $error("unmapped write not refused");

endmodule

/* File: dv/ccrs_board_model.sv */
`timescale 1ns/1ps
// ------------------------------------------------
// board side: reference oscillator and reset source
// ------------------------------------------------
module ccrs_board_model (
  input wire logic clk,
  input wire logic rst_n,
  input wire logic pulseReq,
  input wire logic [1:0] strapSel,
  output logic refClkIn,
  output logic resetPin_n,
  output logic [1:0] ratioStrapPins
);
  logic [1:0] phase;
  logic [5:0] heldRefs;

  // oscillator runs free, one rise every 4 clk; pin is held low after power-on and on each pulse
  always_ff @(posedge clk or negedge rst_n) begin
    if (!rst_n) begin
      phase <= 2'h0;
      refClkIn <= 1'b0;
      resetPin_n <= 1'b0;
      heldRefs <= 6'h00;
      ratioStrapPins <= 2'h0;
    end else begin
      phase <= phase + 2'h1;
      refClkIn <= phase[1];
      if (pulseReq) begin
        resetPin_n <= 1'b0;
        heldRefs <= 6'h00;
        ratioStrapPins <= strapSel; // straps change only while the pin is low
      end else if (!resetPin_n && phase == 2'h3) begin
        heldRefs <= heldRefs + 6'h01;
        // 24 reference cycles low covers both the pulse width and the strap setup
        if (heldRefs == 6'h17) begin
          resetPin_n <= 1'b1;
        end
      end
    end
  end
endmodule

/* File: dv/testbench.sv */
`timescale 1ns/1ps
module testbench;
  logic clk;
  logic rst_n;
  logic pulseReq;
  logic [1:0] strapSel;
  logic refClkIn;
  logic resetPin_n;
  logic [1:0] ratioStrapPins;
  ccrs_pkg::ccrs_axi_req_t axiReq;
  ccrs_pkg::ccrs_axi_rsp_t axiRsp;
  logic coreReset_n;
  logic [6:0] coreMult;
  logic [2:0] coreDiv;
  wire [3:0] ticks;
  int mismatches;
  int testsRun;

  ccrs_core_clock_reset i_dut (.clk(clk), .rst_n(rst_n), .refClkIn(refClkIn), .resetPin_n(resetPin_n),
    .ratioStrapPins(ratioStrapPins), .axiReq(axiReq), .axiRsp(axiRsp), .coreReset_n(coreReset_n),
    .coreMult(coreMult), .coreDiv(coreDiv), .periphTick(ticks[0]), .serialTick(ticks[1]),
    .spiTick(ticks[2]), .dramTick(ticks[3]));
  ccrs_board_model i_board (.clk(clk), .rst_n(rst_n), .pulseReq(pulseReq), .strapSel(strapSel),
    .refClkIn(refClkIn), .resetPin_n(resetPin_n), .ratioStrapPins(ratioStrapPins));

  initial begin
    clk = 1'b0;
    forever #2.5 clk = ~clk;
  end

  // ------------------------------------------------
  // helpers
  // ------------------------------------------------
  task automatic stop_test();
    if (mismatches == 0 && testsRun > 0) begin
      $display("ALL CHECKS OK");
    end else begin
      $display("CHECKS NOT OK");
    end
    $finish;
  endtask

  task automatic check(input logic [31:0] got, input logic [31:0] exp);
    testsRun++;
    if (got !== exp) begin
      mismatches++;
      $display("FAIL t=%0t got=%h exp=%h", $time, got, exp);
    end
  endtask

  // a wait that used its whole bound means a hang, so the run ends here
  task automatic bail(input int n, input int lim);
    if (n >= lim) begin
      mismatches++;
      stop_test();
    end
  endtask

  task automatic board_reset(input logic [1:0] s);
    strapSel <= s;
    pulseReq <= 1'b1;
    @(posedge clk);
    pulseReq <= 1'b0;
    repeat (2) @(posedge clk);
  endtask

  task automatic axi_write(input logic [7:0] a, input logic [31:0] d, input logic [1:0] resp);
    int n;
    n = 0;
    axiReq.awvalid <= 1'b1;
    axiReq.awaddr <= a;
    axiReq.wvalid <= 1'b1;
    axiReq.wdata <= d;
    axiReq.wstrb <= 4'hF;
    axiReq.bready <= 1'b1;
    @(posedge clk);
    while (!(axiRsp.awready === 1'b1 && axiRsp.wready === 1'b1) && n < 50) begin
      @(posedge clk);
      n++;
    end
    axiReq.awvalid <= 1'b0;
    axiReq.wvalid <= 1'b0;
    @(posedge clk);
    while (axiRsp.bvalid !== 1'b1 && n < 50) begin
      @(posedge clk);
      n++;
    end
    axiReq.bready <= 1'b0;
    bail(n, 50);
    check({30'h0, axiRsp.bresp}, {30'h0, resp});
    // one idle edge, so a following call never drives bready twice in one step
    @(posedge clk);
  endtask

  task automatic axi_read(input logic [7:0] a, input logic [31:0] exp, input logic [1:0] resp);
    int n;
    n = 0;
    axiReq.arvalid <= 1'b1;
    axiReq.araddr <= a;
    axiReq.rready <= 1'b1;
    @(posedge clk);
    while (axiRsp.arready !== 1'b1 && n < 50) begin
      @(posedge clk);
      n++;
    end
    axiReq.arvalid <= 1'b0;
    @(posedge clk);
    while (axiRsp.rvalid !== 1'b1 && n < 50) begin
      @(posedge clk);
      n++;
    end
    axiReq.rready <= 1'b0;
    bail(n, 50);
    check(axiRsp.rdata, exp);
    check({30'h0, axiRsp.rresp}, {30'h0, resp});
    @(posedge clk);
  endtask

  // third interval is judged, so a spacing disturbed by a ratio write is skipped
  task automatic check_period(input int s, input int exp);
    int n;
    n = 0;
    for (int k = 0; k < 3; k++) begin
      n = 0;
      @(posedge clk);
      while (ticks[s] !== 1'b1 && n < 200) begin
        @(posedge clk);
        n++;
      end
      bail(n, 200);
    end
    check(32'(n + 1), 32'(exp));
  endtask

  // counts reference rises from pin release to core release; one late rise is tolerated
  task automatic measure_release();
    int n;
    int rises;
    logic lastRef;
    n = 0;
    rises = 0;
    while (resetPin_n !== 1'b1 && n < 500) begin
      @(posedge clk);
      n++;
    end
    bail(n, 500);
    check({31'h0, coreReset_n}, 32'h0);
    lastRef = refClkIn;
    n = 0;
    while (coreReset_n !== 1'b1 && n < 20000) begin
      @(posedge clk);
      n++;
      if (refClkIn && !lastRef) begin
        rises++;
      end
      lastRef = refClkIn;
    end
    bail(n, 20000);
    check(32'(rises == 4097 ? 4096 : rises), 32'h0000_1000);
  endtask

  // ------------------------------------------------
  // scenarios
  // ------------------------------------------------
  task automatic sc_straps();
    logic [6:0] expMult [4];
    expMult = '{7'h10, 7'h20, 7'h06, 7'h10};
    for (int s = 3; s >= 0; s--) begin
      board_reset(2'(s));
      repeat (8) @(posedge clk);
      check(32'(coreMult), 32'(expMult[s]));
      check(32'(coreDiv), 32'h1);
    end
  endtask

  task automatic sc_release();
    measure_release();
    check(32'(coreMult), 32'h10);
    axi_read(ccrs_pkg::ADDR_PWR_CTRL, ccrs_pkg::PWR_CTRL_RST, ccrs_pkg::RESP_OKAY);
  endtask

  task automatic sc_abort();
    board_reset(2'h0);
    repeat (2000) @(posedge clk);
    check({31'h0, coreReset_n}, 32'h0);
    board_reset(2'h0);
    measure_release();
  endtask

  task automatic sc_regs_ticks();
    axi_read(ccrs_pkg::ADDR_SERDIV, ccrs_pkg::SERDIV_RST, ccrs_pkg::RESP_OKAY);
    axi_read(ccrs_pkg::ADDR_SPI_RATE, ccrs_pkg::SPI_RATE_RST, ccrs_pkg::RESP_OKAY);
    axi_read(8'h10, 32'h0, ccrs_pkg::RESP_SLVERR);
    axi_write(8'hF0, 32'h0, ccrs_pkg::RESP_SLVERR);
    check_period(0, 2);
    check_period(1, 8);
    check_period(2, 8);
    check_period(3, 1);
    // dram ratio 2 while its counter still sits at zero; multiplier and divider stay at default
    axi_write(ccrs_pkg::ADDR_PWR_CTRL, 32'h0008_0110, ccrs_pkg::RESP_OKAY);
    check_period(3, 2);
    // multiplier 12, divider 2, input halved, dram ratio 3
    axi_write(ccrs_pkg::ADDR_PWR_CTRL, 32'h000C_060C, ccrs_pkg::RESP_OKAY);
    check(32'(coreMult), 32'h0C);
    check(32'(coreDiv), 32'h4);
    axi_read(ccrs_pkg::ADDR_PWR_CTRL, 32'h000C_060C, ccrs_pkg::RESP_OKAY);
    check_period(3, 3);
    axi_write(ccrs_pkg::ADDR_SERDIV, 32'h0000_0005, ccrs_pkg::RESP_OKAY);
    axi_write(ccrs_pkg::ADDR_SPI_RATE, 32'h0000_0006, ccrs_pkg::RESP_OKAY);
    check_period(1, 10);
    check_period(2, 12);
  endtask

  initial begin
    rst_n = 1'b0;
    pulseReq = 1'b0;
    strapSel = 2'h0;
    axiReq = '0;
    mismatches = 0;
    testsRun = 0;
    repeat (10) @(posedge clk);
    rst_n <= 1'b1;
    @(posedge clk);
    sc_straps();
    sc_release();
    sc_abort();
    sc_regs_ticks();
    stop_test();
  end
endmodule
